// File: core/flash_host_params.svh
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// Register byte offsets on the Avalon side
`define REG_CTRL        5'h00
`define REG_ADDR        5'h04
`define REG_WDATA       5'h08
`define REG_CFG         5'h0c
`define REG_STATUS      5'h10
`define REG_RDATA       5'h14

// Field positions
`define CTRL_OP_LSB     0
`define CTRL_GO_BIT     8
`define CFG_BYPASS_BIT  0
`define CFG_UNPROT_BIT  1
`define CFG_ACCEL_CE_BIT 2

// Reset values
`define CFG_RESET       3'h0
`define ADDR_RESET      25'h0000000
`define WDATA_RESET     16'h0000

// Unlock cycle addresses and data
`define UNLOCK1_ADDR    25'h0000555
`define UNLOCK2_ADDR    25'h00002aa
`define UNLOCK1_DATA    16'h00aa
`define UNLOCK2_DATA    16'h0055

// Command codes
`define CMD_ERASE_SETUP 16'h0080
`define CMD_CHIP_ERASE  16'h0010
`define CMD_BLOCK_ERASE 16'h0030
`define CMD_RESUME      16'h0030
`define CMD_SUSPEND     16'h00b0
`define CMD_READ_RESET  16'h00f0
`define CMD_AUTOSELECT  16'h0090
`define CMD_BUF_WRITE   16'h0025
`define CMD_BUF_CONFIRM 16'h0029
`define BUF_COUNT_ONE   16'h0000

// Polling word bit positions
`define POLL_TOGGLE_BIT 6
`define POLL_TIMER_BIT  3

// Timing, in ns, then derived cycle counts
`define CLK_PERIOD_NS   100
`define T_WE_LOW_NS     100
`define T_READ_ACC_NS   150
`define T_RST_LOW_NS    500
`define WE_CYC  ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC  ((`T_READ_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CYC ((`T_RST_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LAT        2

`endif

// File: core/flash_host_pkg.sv
package flash_host_pkg;

  // Operations software can launch
  typedef enum logic [3:0] {
    OP_READ,
    OP_CHIP_ERASE,
    OP_BLOCK_ERASE,
    OP_BLOCK_ADD,
    OP_ERASE_SUSPEND,
    OP_PROG_SUSPEND,
    OP_RESUME,
    OP_READ_RESET,
    OP_AUTOSELECT,
    OP_ACCEL_PROG,
    OP_POLL,
    OP_HW_RESET
  } op_t;

  // Pin sequencer states
  typedef enum logic [3:0] {
    S_IDLE,
    S_WSETUP,
    S_WLOW,
    S_WHOLD,
    S_RSETUP,
    S_RWAIT,
    S_EVAL,
    S_RST
  } fsm_t;

endpackage : flash_host_pkg

// File: core/flash_sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module flash_sync2 #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;  // First stage, read only by second stage

  // Two stages, constants under reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : flash_sync2

// File: core/flash_cmd_table.sv
`timescale 1ns/1ps
`include "flash_host_params.svh"
// Address/data of each bus write cycle of an operation
module flash_cmd_table (
  // Selection
  input  flash_host_pkg::op_t op_i,
  input  wire logic [3:0]     step_i,
  input  wire logic           bypass_i,
  input  wire logic [24:0]    addr_i,
  input  wire logic [15:0]    wdata_i,
  // Cycle contents
  output logic      [24:0]    caddr_o,
  output logic      [15:0]    cdata_o,
  output logic                last_o
);
  import flash_host_pkg::*;

  // Standard unlock-prefixed sequences are indexed by step
  always_comb begin
    caddr_o = `UNLOCK1_ADDR;
    cdata_o = `UNLOCK1_DATA;
    last_o  = 1'b1;
    case (op_i)
      OP_CHIP_ERASE, OP_BLOCK_ERASE: begin
        if (bypass_i) begin  // Two cycles in bypass
          caddr_o = (step_i == 4'h0) ? `UNLOCK1_ADDR : addr_i;
          cdata_o = (step_i == 4'h0) ? `CMD_ERASE_SETUP :
                    (op_i == OP_CHIP_ERASE) ? `CMD_CHIP_ERASE :
                                              `CMD_BLOCK_ERASE;
          last_o  = (step_i == 4'h1);
        end else begin  // Six cycles otherwise
          case (step_i)
            4'h1, 4'h4: begin
              caddr_o = `UNLOCK2_ADDR;
              cdata_o = `UNLOCK2_DATA;
            end
            4'h2: cdata_o = `CMD_ERASE_SETUP;
            4'h5: begin
              caddr_o = (op_i == OP_CHIP_ERASE) ? `UNLOCK1_ADDR : addr_i;
              cdata_o = (op_i == OP_CHIP_ERASE) ? `CMD_CHIP_ERASE :
                                                  `CMD_BLOCK_ERASE;
            end
            default: ;
          endcase
          last_o = (step_i == 4'h5);
        end
      end
      OP_BLOCK_ADD: begin  // Repeat of the final cycle
        caddr_o = addr_i;
        cdata_o = `CMD_BLOCK_ERASE;
      end
      OP_ERASE_SUSPEND, OP_PROG_SUSPEND: begin  // Address ignored
        caddr_o = addr_i;
        cdata_o = `CMD_SUSPEND;
      end
      OP_RESUME: begin  // One cycle resume
        caddr_o = addr_i;
        cdata_o = `CMD_RESUME;
      end
      OP_READ_RESET: begin  // Clears error, ends timeout window
        caddr_o = addr_i;
        cdata_o = `CMD_READ_RESET;
      end
      OP_AUTOSELECT: begin  // Identifier entry, also in suspend
        case (step_i)
          4'h1: begin
            caddr_o = `UNLOCK2_ADDR;
            cdata_o = `UNLOCK2_DATA;
          end
          4'h2: cdata_o = `CMD_AUTOSELECT;
          default: ;
        endcase
        last_o = (step_i == 4'h2);
      end
      OP_ACCEL_PROG: begin  // Short buffered write under high voltage
        caddr_o = (step_i == 4'h2) ? addr_i : addr_i;
        case (step_i)
          4'h0: cdata_o = `CMD_BUF_WRITE;
          4'h1: cdata_o = `BUF_COUNT_ONE;
          4'h2: cdata_o = wdata_i;
          default: cdata_o = `CMD_BUF_CONFIRM;
        endcase
        last_o = (step_i == 4'h3);
      end
      default: ;
    endcase
  end

endmodule : flash_cmd_table

// File: core/flash_host.sv
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "flash_host_params.svh"

module flash_host #(
  parameter int POLL_LIMIT = 65535  // Toggle reads before timeout
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Flash pins
  output logic      [24:0] flash_addr_o,
  input  wire logic [15:0] flash_dq_i,
  output logic      [15:0] flash_dq_o,
  output logic             flash_dq_oe_n_o,
  output logic             flash_ce_n_o,
  output logic             flash_oe_n_o,
  output logic             flash_we_n_o,
  output logic             flash_rst_n_o,
  output logic             high_voltage_level_o
);
  import flash_host_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    fsm_t        st;        // Pin sequencer state
    op_t         op;        // Operation in progress
    logic [3:0]  step;      // Write cycle index
    logic [7:0]  cnt;       // Pin timing counter
    logic [15:0] poll_cnt;  // Toggle reads so far
    logic        chk;       // First poll read taken
    logic [15:0] prev;      // Previous polling word
    logic [24:0] fa;        // Address pins
    logic [15:0] fdo;       // Data pins out
    logic        dq_oe_n;   // Data drive enable, low drives
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        frst_n;    // Device reset pin
    logic        high_voltage_level;       // High-voltage request
    logic        waitreq;   // Avalon waitrequest
    logic [31:0] rdata;     // Avalon read data
    logic [24:0] addr;      // Target address register
    logic [15:0] wdata;     // Program data register
    logic [2:0]  cfg;       // Configuration bits
    logic        busy;
    logic        done;      // Sticky until next launch
    logic        tmo;       // Poll timeout
    logic        late;      // Block add refused, timer expired
    logic        refused;   // Launch refused
    logic [15:0] last;      // Last word read from the device
  } state_t;

  state_t      s_q;         // Registered state
  state_t      s_d;         // Next state
  logic [15:0] dq_sync;     // Synchronised data pins
  logic [24:0] caddr;       // Table address for this step
  logic [15:0] cdata;       // Table data for this step
  logic        clast;       // Step is the final write
  logic        bypass;      // Short sequences in use
  logic [31:0] rd_mux;      // Register read value
  op_t         new_op;      // Operation being launched
  logic        need_vhh;    // Launch wants the high voltage

  // Data pins cross from the device's timing
  flash_sync2 #(
    .WIDTH (16)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (flash_dq_i),
    .sync_o  (dq_sync)
  );

  // High voltage forces the device into bypass
  assign bypass = s_q.cfg[`CFG_BYPASS_BIT] | s_q.high_voltage_level;

  // Cycle contents for the current step
  flash_cmd_table u_table (
    .op_i     (s_q.op),
    .step_i   (s_q.step),
    .bypass_i (bypass),
    .addr_i   (s_q.addr),
    .wdata_i  (s_q.wdata),
    .caddr_o  (caddr),
    .cdata_o  (cdata),
    .last_o   (clast)
  );

  assign new_op   = op_t'(avs_writedata_i[`CTRL_OP_LSB +: 4]);
  // High voltage only for these two operations
  assign need_vhh = (new_op == OP_ACCEL_PROG) ||
                    ((new_op == OP_CHIP_ERASE) &&
                     s_q.cfg[`CFG_ACCEL_CE_BIT]);

  // Register read decode, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `REG_ADDR:   rd_mux = {7'h0, s_q.addr};
      `REG_WDATA:  rd_mux = {16'h0, s_q.wdata};
      `REG_CFG:    rd_mux = {29'h0, s_q.cfg};
      `REG_STATUS: rd_mux = {24'h0, bypass, s_q.high_voltage_level, s_q.refused,
                             s_q.late, s_q.tmo, s_q.done, s_q.busy, 1'b0};
      `REG_RDATA:  rd_mux = {16'h0, s_q.last};
      default:     rd_mux = 32'h0;
    endcase
  end

  // Next-state logic for bus slave and pin sequencer
  always_comb begin
    s_d = s_q;
    // Waitrequest drops for one cycle per request
    if (!s_q.waitreq) begin
      s_d.waitreq = 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      s_d.waitreq = 1'b0;
      s_d.rdata   = rd_mux;
    end

    // Sequencer
    case (s_q.st)
      S_IDLE: s_d.frst_n = 1'b1;  // Device leaves reset after ours
      S_WSETUP: begin  // Address, data, chip enable, write strobe
        s_d.fa      = caddr;
        s_d.fdo     = cdata;
        s_d.dq_oe_n = 1'b0;
        s_d.ce_n    = 1'b0;
        s_d.we_n    = 1'b0;
        s_d.cnt     = 8'h0;
        s_d.st      = S_WLOW;
      end
      S_WLOW: begin
        if (s_q.cnt == 8'(`WE_CYC - 1)) begin
          s_d.we_n = 1'b1;  // Device latches data on this rise
          s_d.st   = S_WHOLD;
        end else begin
          s_d.cnt = s_q.cnt + 8'h1;
        end
      end
      S_WHOLD: begin
        s_d.ce_n    = 1'b1;
        s_d.dq_oe_n = 1'b1;
        if (!clast) begin
          s_d.step = s_q.step + 4'h1;
          s_d.st   = S_WSETUP;
        end else if (s_q.op == OP_CHIP_ERASE || s_q.op == OP_RESUME ||
                     s_q.op == OP_ACCEL_PROG) begin
          // Busy through completion so nothing interrupts
          s_d.chk      = 1'b0;
          s_d.poll_cnt = 16'h0;
          s_d.st       = S_RSETUP;
        end else begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st   = S_IDLE;
        end
      end
      S_RSETUP: begin  // Read at target; device picks array or status
        s_d.fa      = s_q.addr;
        s_d.dq_oe_n = 1'b1;
        s_d.ce_n    = 1'b0;
        s_d.oe_n    = 1'b0;
        s_d.cnt     = 8'h0;
        s_d.st      = S_RWAIT;
      end
      S_RWAIT: begin  // Access time plus synchroniser delay
        if (s_q.cnt == 8'(`RD_CYC + `SYNC_LAT - 1)) begin
          s_d.last = dq_sync;
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.st   = S_EVAL;
        end else begin
          s_d.cnt = s_q.cnt + 8'h1;
        end
      end
      S_EVAL: begin
        case (s_q.op)
          OP_BLOCK_ADD: begin
            if (s_q.last[`POLL_TIMER_BIT]) begin  // Window closed
              s_d.late = 1'b1;
              s_d.busy = 1'b0;
              s_d.st   = S_IDLE;
            end else begin
              s_d.step = 4'h0;
              s_d.st   = S_WSETUP;
            end
          end
          OP_CHIP_ERASE, OP_RESUME, OP_ACCEL_PROG, OP_POLL: begin
            s_d.prev = s_q.last;
            if (!s_q.chk) begin
              s_d.chk = 1'b1;
              s_d.st  = S_RSETUP;
            end else if (s_q.last[`POLL_TOGGLE_BIT] ==
                         s_q.prev[`POLL_TOGGLE_BIT]) begin
              s_d.high_voltage_level  = 1'b0;  // Finished: drop high voltage
              s_d.busy = 1'b0;
              s_d.done = 1'b1;
              s_d.st   = S_IDLE;
            end else if (s_q.poll_cnt == 16'(POLL_LIMIT)) begin
              s_d.tmo  = 1'b1;  // Voltage stays; software must reset
              s_d.busy = 1'b0;
              s_d.st   = S_IDLE;
            end else begin
              s_d.poll_cnt = s_q.poll_cnt + 16'h1;
              s_d.st       = S_RSETUP;
            end
          end
          default: begin  // Plain read
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = S_IDLE;
          end
        endcase
      end
      S_RST: begin  // Reset pulse on the device pin
        if (s_q.cnt == 8'(`RST_CYC - 1)) begin
          s_d.frst_n = 1'b1;
          s_d.busy   = 1'b0;
          s_d.done   = 1'b1;
          s_d.st     = S_IDLE;
        end else begin
          s_d.cnt = s_q.cnt + 8'h1;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    // Register writes take effect at the acknowledging edge
    if (avs_write_i && !s_q.waitreq && (avs_byteenable_i != 4'h0)) begin
      case (avs_address_i)
        `REG_ADDR:  s_d.addr  = avs_writedata_i[24:0];
        `REG_WDATA: s_d.wdata = avs_writedata_i[15:0];
        `REG_CFG:   s_d.cfg   = avs_writedata_i[2:0];
        `REG_CTRL: begin
          if (avs_writedata_i[`CTRL_GO_BIT]) begin
            if (s_q.busy) begin
              s_d.refused = 1'b1;  // One operation at a time
            end else if (need_vhh && !s_q.cfg[`CFG_UNPROT_BIT]) begin
              s_d.refused = 1'b1;  // Blocks not confirmed unprotected
            end else begin
              s_d.op      = new_op;
              s_d.busy    = 1'b1;
              s_d.done    = 1'b0;
              s_d.tmo     = 1'b0;
              s_d.late    = 1'b0;
              s_d.refused = 1'b0;
              s_d.step    = 4'h0;
              s_d.cnt     = 8'h0;
              s_d.chk     = 1'b0;
              s_d.poll_cnt = 16'h0;
              if (new_op == OP_HW_RESET) begin
                s_d.frst_n = 1'b0;
                s_d.high_voltage_level    = 1'b0;
                s_d.st     = S_RST;
              end else if (new_op == OP_READ || new_op == OP_POLL ||
                           new_op == OP_BLOCK_ADD) begin
                s_d.st = S_RSETUP;  // Block add checks the timer first
              end else begin
                s_d.high_voltage_level = s_q.high_voltage_level | need_vhh;
                s_d.st  = S_WSETUP;
              end
            end
          end
        end
        default: ;
      endcase
    end
  end

  // State register; device held in reset with ours
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q         <= '0;
      s_q.st      <= S_IDLE;
      s_q.op      <= OP_READ;
      s_q.dq_oe_n <= 1'b1;
      s_q.ce_n    <= 1'b1;
      s_q.oe_n    <= 1'b1;
      s_q.we_n    <= 1'b1;
      s_q.waitreq <= 1'b1;
      s_q.addr    <= `ADDR_RESET;
      s_q.wdata   <= `WDATA_RESET;
      s_q.cfg     <= `CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_o       = s_q.rdata;
  assign avs_waitrequest_o    = s_q.waitreq;
  assign flash_addr_o         = s_q.fa;
  assign flash_dq_o           = s_q.fdo;
  assign flash_dq_oe_n_o      = s_q.dq_oe_n;
  assign flash_ce_n_o         = s_q.ce_n;
  assign flash_oe_n_o         = s_q.oe_n;
  assign flash_we_n_o         = s_q.we_n;
  assign flash_rst_n_o        = s_q.frst_n;
  assign high_voltage_level_o = s_q.high_voltage_level;

endmodule : flash_host

// File: verification/flash_host_props.sv
`timescale 1ns/1ps
// Port checker for the flash host controller
module flash_host_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // Avalon side
  input wire logic [4:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Flash pins
  input wire logic [24:0] flash_addr_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic        flash_dq_oe_n_o,
  input wire logic        flash_ce_n_o,
  input wire logic        flash_oe_n_o,
  input wire logic        flash_we_n_o,
  input wire logic        flash_rst_n_o,
  input wire logic        high_voltage_level_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Slave answers one cycle after taking a request
  ack_next_a: assert property ($rose(avs_read_i | avs_write_i)
    |=> !avs_waitrequest_o) else $error("late bus answer");
  // Answer stands one cycle only
  ack_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  idle_wait_a: assert property (!(avs_read_i || avs_write_i)
    |-> avs_waitrequest_o) else $error("answer without request");
  unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
    !(avs_address_i inside {5'h04, 5'h08, 5'h0c, 5'h10, 5'h14})
    && avs_address_i != 5'h00 |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  // Write strobe only with chip select and driven data
  we_qualified_a: assert property (!flash_we_n_o |-> !flash_ce_n_o &&
    !flash_dq_oe_n_o && flash_oe_n_o) else $error("bad write strobe");
  // Never drive the data pins while the device does
  read_no_drive_a: assert property (!flash_oe_n_o |->
    flash_dq_oe_n_o && flash_we_n_o) else $error("bus contention");
  write_hold_a: assert property ($rose(flash_we_n_o) |->
    $stable(flash_addr_o) && $stable(flash_dq_o) && !flash_dq_oe_n_o)
    else $error("write data not held");
  // Device reset pulse is five cycles and drops high voltage
  reset_pulse_a: assert property ($fell(flash_rst_n_o) |=>
    !flash_rst_n_o [*4] ##1 (flash_rst_n_o && !high_voltage_level_o))
    else $error("bad device reset pulse");
  read_strobe_a: assert property ($fell(flash_oe_n_o) |->
    !flash_oe_n_o [*4]) else $error("read strobe too short");
  // No suspend or resume code while high voltage is applied
  vhh_no_susp_a: assert property (high_voltage_level_o &&
    !flash_we_n_o |-> flash_dq_o[7:0] != 8'hb0 &&
    flash_dq_o[7:0] != 8'h30) else $error("command under high voltage");

  cover property (avs_write_i && !avs_waitrequest_o);
  cover property ($fell(flash_rst_n_o));
  cover property ($rose(high_voltage_level_o));
endmodule : flash_host_props

bind flash_host flash_host_props props_inst (.clk_i, .rst_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
  .avs_waitrequest_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_n_o,
  .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o,
  .high_voltage_level_o);

// File: verification/flash_dev_model.sv
`timescale 1ns/1ps
// Behavioural parallel flash, command layer only
module flash_dev_model #(
  parameter int TMO_NS  = 5000,  // Block erase window
  parameter int BUSY_NS = 3000   // Erase or program time
) (
  // Pins from the host
  input  wire logic [24:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        rst_n_i,
  input  wire logic        vhh_i,
  // Data towards the host
  output logic      [15:0] dq_o
);
  int          mode_q = 0;  // 0 read, 1 locked busy, 2 block, 3 susp
  time         t_win  = 0;  // Block erase window end
  time         t_end  = 0;  // Embedded operation end
  logic        tog_q  = 0;  // Toggle bit state
  logic        arm_q  = 0;  // Erase setup seen
  logic        hv_wr  = 0;  // High voltage seen at last write
  logic [15:0] rd_q   = 0;  // Last word read out
  logic [15:0] last_d = 0;
  logic [24:0] last_a = 0;
  logic [8:0]  blk    = 0;  // Block under erase
  logic [7:0]  c;
  int          n_wr   = 0;

  // Commands latch on the rising write strobe
  always @(posedge we_n_i or negedge rst_n_i) begin
    c = dq_i[7:0];
    if (!rst_n_i) begin
      mode_q = 0;
    end else if (!ce_n_i) begin
      n_wr++;
      last_a = addr_i;
      last_d = dq_i;
      hv_wr  = vhh_i;  // High voltage means bypass
      case (mode_q)
        1: ;  // Everything ignored
        2: if (c == 8'hb0) begin
             mode_q = 3;  // Window ends at once
             t_win  = $time;
           end else if ($time < t_win && c == 8'h30) begin
             t_win = $time + TMO_NS;
             t_end = t_win + BUSY_NS;
           end else if ($time < t_win) begin
             mode_q = 0;
           end
        3: if (c == 8'h30) begin
             mode_q = 2;
             t_end  = $time + BUSY_NS;
           end
        default: if (c == 8'h80) begin
             arm_q = 1;
           end else if (arm_q && c == 8'h10) begin
             arm_q  = 0;
             mode_q = 1;
             t_end  = $time + BUSY_NS;
           end else if (arm_q && c == 8'h30) begin
             arm_q  = 0;
             blk    = addr_i[24:16];
             mode_q = 2;
             t_win  = $time + TMO_NS;
             t_end  = t_win + BUSY_NS;
           end else if (c == 8'h29) begin
             mode_q = 1;
             t_end  = $time + BUSY_NS;
           end
      endcase
    end
  end

  // Polling word while busy or from the suspended block, array data otherwise; settle after strobe
  always @(negedge oe_n_i) #1 if (!ce_n_i) begin
    if (mode_q inside {1, 2} && $time >= t_end) mode_q = 0;
    if (mode_q inside {1, 2} ||
        (mode_q == 3 && addr_i[24:16] == blk)) begin
      tog_q = ~tog_q;
      rd_q  = {9'h0, tog_q, 2'b00, $time >= t_win, 3'b000};
    end else begin
      rd_q = addr_i[15:0] ^ 16'h5a5a;
    end
  end

  // Released bus shows the inverse so stale data never passes
  assign dq_o = (!ce_n_i && !oe_n_i) ? rd_q : ~rd_q;
endmodule : flash_dev_model

// File: verification/tb_flash_host.sv
`timescale 1ns/1ps
`include "flash_host_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_flash_host;
  import flash_host_pkg::*;
  logic        clk_i = 0;
  logic        rst_n_i = 0;
  logic [4:0]  avs_address_i = 0;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = 0;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o;
  logic [24:0] flash_addr_o;
  logic [15:0] flash_dq_o, dq_dev, dq_w;
  logic        flash_dq_oe_n_o, flash_ce_n_o, flash_oe_n_o;
  logic        flash_we_n_o, flash_rst_n_o, high_voltage_level_o;
  int          err_count = 0;
  int          n_checks = 0;
  int          w;
  int          cfgs[3] = '{0, 1, 6};  // Plain, bypass, high voltage
  int          nexp[3] = '{6, 2, 2};

  always #50 clk_i = ~clk_i;
  // Shared data wire: host wins only while it enables its drivers
  assign dq_w = flash_dq_oe_n_o ? dq_dev : flash_dq_o;

  flash_host #(.POLL_LIMIT(64)) flash_host_inst (.clk_i, .rst_n_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
    .flash_addr_o, .flash_dq_i(dq_w), .flash_dq_o, .flash_dq_oe_n_o,
    .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_rst_n_o,
    .high_voltage_level_o);
  flash_dev_model flash_dev_model_inst (.addr_i(flash_addr_o),
    .dq_i(dq_w), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
    .we_n_i(flash_we_n_o), .rst_n_i(flash_rst_n_o),
    .vhh_i(high_voltage_level_o), .dq_o(dq_dev));

  // One Avalon access; held until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    do @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : av

  // Launch an operation and poll status until not busy
  task automatic op(input op_t o, input logic [24:0] a);
    av(1'b1, `REG_ADDR, {7'h0, a});
    av(1'b1, `REG_CTRL, {23'h0, 1'b1, 4'h0, o});
    for (int i = 0; i < 400; i++) begin
      av(1'b0, `REG_STATUS, 32'h0);
      if (rd[1] === 1'b0) break;
    end
  endtask : op

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    err_count++;
    summarize();
  end

  // Test sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    `CHK("idle pins", 4'hf, {flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_n_o})
    `CHK("device reset", 1'b1, flash_rst_n_o)
    av(1'b0, `REG_STATUS, 32'h0);
    `CHK("status", 32'h0, rd)
    av(1'b1, 5'h1c, 32'h7);
    av(1'b0, 5'h1c, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    av(1'b0, `REG_CFG, 32'h0);
    `CHK("cfg", 32'h0, rd)
    $display("TEST reset done");
    for (int b = 0; b < 3; b++) begin
      av(1'b1, `REG_CFG, cfgs[b]);
      w = flash_dev_model_inst.n_wr;
      op(OP_CHIP_ERASE, 25'h0);
      `CHK("erase writes", nexp[b], flash_dev_model_inst.n_wr - w)
      `CHK("erase code", 16'h0010, flash_dev_model_inst.last_d)
      `CHK("erase done", 2'b10, rd[2:1])
      `CHK("vhh off", 1'b0, high_voltage_level_o)
    end
    $display("TEST chip erase done");
    av(1'b1, `REG_CFG, 32'h0);
    w = flash_dev_model_inst.n_wr;
    op(OP_BLOCK_ERASE, 25'h20000);
    `CHK("block writes", 6, flash_dev_model_inst.n_wr - w)
    `CHK("block code", 16'h0030, flash_dev_model_inst.last_d)
    op(OP_BLOCK_ADD, 25'h40000);
    `CHK("add write", 7, flash_dev_model_inst.n_wr - w)
    `CHK("add addr", 25'h40000, flash_dev_model_inst.last_a)
    `CHK("not late", 1'b0, rd[4])
    repeat (60) @(posedge clk_i);
    op(OP_BLOCK_ADD, 25'h60000);
    `CHK("late", 1'b1, rd[4])
    `CHK("no late write", 7, flash_dev_model_inst.n_wr - w)
    op(OP_POLL, 25'h0);
    `CHK("poll done", 2'b10, rd[2:1])
    `CHK("read mode", 0, flash_dev_model_inst.mode_q)
    $display("TEST block erase done");
    op(OP_BLOCK_ERASE, 25'h20000);
    op(OP_ERASE_SUSPEND, 25'h0);
    `CHK("suspend code", 16'h00b0, flash_dev_model_inst.last_d)
    `CHK("suspended", 3, flash_dev_model_inst.mode_q)
    op(OP_READ, 25'h00123);
    av(1'b0, `REG_RDATA, 32'h0);
    `CHK("array word", 32'h0123 ^ 32'h5a5a, rd)
    op(OP_READ, 25'h20000);
    av(1'b0, `REG_RDATA, 32'h0);
    `CHK("susp block", 9'h0, rd[15:7])
    op(OP_RESUME, 25'h0);
    `CHK("resume code", 16'h0030, flash_dev_model_inst.last_d)
    `CHK("resume done", 0, flash_dev_model_inst.mode_q)
    op(OP_BLOCK_ERASE, 25'h20000);
    op(OP_READ_RESET, 25'h0);
    `CHK("reset code", 16'h00f0, flash_dev_model_inst.last_d)
    `CHK("abandoned", 0, flash_dev_model_inst.mode_q)
    $display("TEST suspend done");
    w = flash_dev_model_inst.n_wr;
    op(OP_ACCEL_PROG, 25'h100);
    `CHK("refused", 1'b1, rd[5])
    `CHK("no writes", 0, flash_dev_model_inst.n_wr - w)
    av(1'b1, `REG_CFG, 32'h2);
    av(1'b1, `REG_WDATA, 32'h1234);
    op(OP_ACCEL_PROG, 25'h100);
    `CHK("accel writes", 4, flash_dev_model_inst.n_wr - w)
    `CHK("confirm", 16'h0029, flash_dev_model_inst.last_d)
    `CHK("vhh at write", 1'b1, flash_dev_model_inst.hv_wr)
    `CHK("vhh dropped", 1'b0, high_voltage_level_o)
    op(OP_BLOCK_ERASE, 25'h20000);
    op(OP_HW_RESET, 25'h0);
    `CHK("hw reset", 0, flash_dev_model_inst.mode_q)
    `CHK("hw done", 1'b1, rd[2])
    $display("TEST access and reset done");
    summarize();
  end
endmodule : tb_flash_host
